// *** hw/hri_consts.vh ***
// Constants for the handler result interface
// Assumes a 250 MHz core clock and a 32-bit AXI4-Lite register port
`ifndef HRI_CONSTS_VH
`define HRI_CONSTS_VH
// ************
// Register map
// ************
`define HRI_ADDR_W 8
`define HRI_REG_CTRL 8'h00
`define HRI_REG_STATUS 8'h04
`define HRI_REG_IRQ_STAT 8'h08
`define HRI_REG_IRQ_MASK 8'h0c
`define HRI_REG_RESULT 8'h10
`define HRI_REG_CMD 8'h14
// ************
// Control fields
// ************
`define HRI_CTRL_MEASURE_START_IN_N 0
`define HRI_CTRL_CMP_EN 1
`define HRI_CTRL_CC_EN 2
`define HRI_CTRL_W 3
`define HRI_CTRL_RESET 3'h0
// ************
// Result fields (written by software over AXI4-Lite)
// ************
`define HRI_RES_PRI_LSB 0
`define HRI_RES_SEC_LSB 2
`define HRI_RES_NC 4
`define HRI_RES_W 5
`define HRI_VERD_IN 2'h0
`define HRI_VERD_HI 2'h1
`define HRI_VERD_LO 2'h2
// ************
// Command bits (write one to act)
// ************
`define HRI_CMD_ANALOG_DONE 0
`define HRI_CMD_MEAS_DONE 1
`define HRI_CMD_SW_TRIG 2
`define HRI_CMD_HALT_ERR 3
`define HRI_CMD_ALARM_SET 4
`define HRI_CMD_ALARM_CLR 5
// ************
// Event bits
// ************
`define HRI_EV_TRIG 0
`define HRI_EV_ANALOG 1
`define HRI_EV_DONE 2
`define HRI_EV_ALARM 3
`define HRI_EV_W 4
// ************
// Timing
// ************
`define HRI_TRIG_MIN_NS 1000
`define HRI_CLK_NS 4
`define HRI_TRIG_MIN_CYC ((`HRI_TRIG_MIN_NS + `HRI_CLK_NS - 1) / `HRI_CLK_NS)
`define HRI_RESP_OKAY 2'b00
`define HRI_RESP_SLVERR 2'b10
`endif

// *** hw/hri_sync.v ***
// Two-flop synchroniser for handler-side pins
// Assumes inputs are asynchronous to core_clk
`include "hri_consts.vh"
module hri_sync (
	input wire core_clk,
	input wire srst,
	input wire [1:0] async_in,
	output reg [1:0] sync_out
);
	reg [1:0] stage1;
	// Idle level of active-low pins is high
	always @(posedge core_clk) begin
		if (srst) begin
			stage1 <= 2'h3;
			sync_out <= 2'h3;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// *** hw/hri_top.v ***
// Handler result interface: trigger and lockout inputs, active-low verdicts
// Assumes handler pins are asynchronous; software on AXI4-Lite feeds results
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`include "hri_consts.vh"
// How it works
// R1: External mode starts measurement on trigger rise
// R2: Handler holds trigger beyond one microsecond
// R3: Lockout input disables all front-panel keys
// R4: All handler outputs are low when asserted
// R5: Primary verdict output matches primary result
// R6: Secondary verdict output matches secondary result
// R7: No-contact asserted when contact check fails
// R8: Alarm on power failure or listed errors
// R9: Analog-done asserted when analog phase finishes
// R10: Handler reads results only after end
// R11: End strobe only after verdicts valid; here the end strobe and verdicts both follow meas_done in the same cycle
// R12: Verdicts and strobes driven only with comparator
// R13: No-contact needs comparator and contact check
// R14: Halted device ignores further triggers
// R15: Halted device freezes verdict and strobe outputs
// R16: Contact failure still completes normal sequence
// R17: Handler lockout covers toggle key too
// R18: At most one verdict per parameter
// R19: New trigger clears analog-done and end strobes
module hri_top (
	input wire core_clk,
	input wire srst,
	input wire measure_start_in_n,
	input wire key_lock_in_n,
	input wire power_fail,
	input wire [`HRI_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`HRI_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg primary_above_limit_n,
	output reg primary_within_limit_n,
	output reg primary_below_limit_n,
	output reg secondary_above_limit_n,
	output reg secondary_within_limit_n,
	output reg secondary_below_limit_n,
	output reg no_contact_n,
	output reg alarm_n,
	output reg analog_done_n,
	output reg result_valid_n,
	output reg keys_locked,
	output reg measure_start,
	output reg irq
);
	// ************
	// Pin synchronisers
	// ************
	wire [1:0] pins_sync;
	hri_sync u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.async_in({key_lock_in_n, measure_start_in_n}),
		.sync_out(pins_sync)
	);
	wire trig_n_s = pins_sync[0];
	wire lock_n_s = pins_sync[1];

	reg trig_prev_n;
	reg [`HRI_CTRL_W-1:0] ctrl;
	reg [`HRI_RES_W-1:0] result;
	reg [`HRI_EV_W-1:0] irq_stat;
	reg [`HRI_EV_W-1:0] irq_mask;
	reg halted;
	reg err_alarm;
	reg busy;
	reg analog_phase_done;
	reg meas_done;

	// Verdict decode, shared by both parameters
	function [2:0] verd_n;
		input [1:0] code;
		begin
			verd_n = 3'h7;
			// Bit order is above, within, below
			if (code == `HRI_VERD_HI)
				verd_n = 3'h3;
			else if (code == `HRI_VERD_IN)
				verd_n = 3'h5;
			else if (code == `HRI_VERD_LO)
				verd_n = 3'h6;
		end
	endfunction

	// ************
	// Bus write decode
	// ************
	reg [`HRI_ADDR_W-1:0] aw_hold;
	reg [31:0] w_hold;
	reg aw_have;
	reg w_have;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire [`HRI_ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_hold;
	wire [31:0] wr_data = w_take ? s_axi_wdata : w_hold;
	wire wr_fire = (aw_have | aw_take) & (w_have | w_take) & ~s_axi_bvalid;
	wire wr_ctrl = wr_fire & (wr_addr == `HRI_REG_CTRL);
	wire wr_mask = wr_fire & (wr_addr == `HRI_REG_IRQ_MASK);
	wire wr_res = wr_fire & (wr_addr == `HRI_REG_RESULT);
	wire wr_cmd = wr_fire & (wr_addr == `HRI_REG_CMD);
	wire wr_known = (wr_addr == `HRI_REG_CTRL) | (wr_addr == `HRI_REG_STATUS) |
		(wr_addr == `HRI_REG_IRQ_STAT) | (wr_addr == `HRI_REG_IRQ_MASK) |
		(wr_addr == `HRI_REG_RESULT) | (wr_addr == `HRI_REG_CMD);
	wire [31:0] cmd = wr_cmd ? wr_data : 32'h0;

	always @(posedge core_clk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `HRI_RESP_OKAY;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_hold <= {`HRI_ADDR_W{1'b0}};
			w_hold <= 32'h0;
		end else begin
			if (aw_take) begin
				aw_hold <= s_axi_awaddr;
			end
			if (w_take) begin
				w_hold <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `HRI_RESP_OKAY : `HRI_RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_have <= 1'b1;
					s_axi_awready <= 1'b0;
				end
				if (w_take) begin
					w_have <= 1'b1;
					s_axi_wready <= 1'b0;
				end
				if (s_axi_bvalid & s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
					s_axi_awready <= 1'b1;
					s_axi_wready <= 1'b1;
				end
			end
		end
	end

	// ************
	// Measurement sequencing
	// ************
	wire ext_edge = trig_n_s & ~trig_prev_n; // R1
	wire trig_ok = ~halted & // R14
		((ctrl[`HRI_CTRL_MEASURE_START_IN_N] & ext_edge) |
		(~ctrl[`HRI_CTRL_MEASURE_START_IN_N] & cmd[`HRI_CMD_SW_TRIG])); // R1
	wire analog_ev = busy & ~analog_phase_done & cmd[`HRI_CMD_ANALOG_DONE];
	// Done implies analog done, so a lone done command covers both stages
	wire done_ev = busy & cmd[`HRI_CMD_MEAS_DONE];
	wire alarm_now = power_fail | err_alarm; // R8
	wire alarm_rise = alarm_now & alarm_n;
	wire [`HRI_EV_W-1:0] events = {alarm_rise, done_ev, analog_ev | done_ev, trig_ok};
	wire rd_stat = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `HRI_REG_IRQ_STAT);
	wire cmp_on = ctrl[`HRI_CTRL_CMP_EN];
	wire [2:0] pri_n = verd_n(result[`HRI_RES_PRI_LSB +: 2]);
	wire [2:0] sec_n = verd_n(result[`HRI_RES_SEC_LSB +: 2]);

	always @(posedge core_clk) begin
		if (srst) begin
			trig_prev_n <= 1'b1;
			ctrl <= `HRI_CTRL_RESET;
			result <= {`HRI_RES_W{1'b0}};
			irq_mask <= {`HRI_EV_W{1'b0}};
			irq_stat <= {`HRI_EV_W{1'b0}};
			halted <= 1'b0;
			err_alarm <= 1'b0;
			busy <= 1'b0;
			analog_phase_done <= 1'b0;
			meas_done <= 1'b0;
			measure_start <= 1'b0;
			irq <= 1'b0;
		end else begin
			trig_prev_n <= trig_n_s;
			measure_start <= trig_ok;
			if (wr_ctrl) begin
				ctrl <= wr_data[`HRI_CTRL_W-1:0];
			end
			if (wr_mask) begin
				irq_mask <= wr_data[`HRI_EV_W-1:0];
			end
			// Results frozen once halted
			if (wr_res & ~halted) begin
				result <= wr_data[`HRI_RES_W-1:0];
			end
			if (cmd[`HRI_CMD_HALT_ERR]) begin
				halted <= 1'b1;
				err_alarm <= 1'b1;
			end
			if (cmd[`HRI_CMD_ALARM_SET]) begin
				err_alarm <= 1'b1;
			end else if (cmd[`HRI_CMD_ALARM_CLR] & ~cmd[`HRI_CMD_HALT_ERR]) begin
				err_alarm <= 1'b0;
			end
			if (trig_ok) begin
				busy <= 1'b1;
				analog_phase_done <= 1'b0; // R19
				meas_done <= 1'b0; // R19
			end else if (~halted) begin
				if (analog_ev | done_ev) begin
					analog_phase_done <= 1'b1; // R9
				end
				if (done_ev) begin
					meas_done <= 1'b1; // R11
					busy <= 1'b0;
				end
			end
			// Set wins over the read clear
			irq_stat <= (rd_stat ? {`HRI_EV_W{1'b0}} : irq_stat) | events;
			irq <= |(((rd_stat ? {`HRI_EV_W{1'b0}} : irq_stat) | events) & irq_mask);
		end
	end

	// ************
	// Handler outputs, active low, plus the active-high key lock
	// ************
	always @(posedge core_clk) begin
		if (srst) begin
			{primary_above_limit_n, primary_within_limit_n, primary_below_limit_n} <= 3'h7;
			{secondary_above_limit_n, secondary_within_limit_n, secondary_below_limit_n} <= 3'h7;
			no_contact_n <= 1'b1;
			alarm_n <= 1'b1;
			analog_done_n <= 1'b1;
			result_valid_n <= 1'b1;
			keys_locked <= 1'b0;
		end else begin
			alarm_n <= ~alarm_now; // R4 R8
			// Only the handler pin sets this lock; the pin or reset releases it
			keys_locked <= ~lock_n_s; // R3 R17
			if (~halted) begin // R15
				if (cmp_on) begin // R12
					// Verdicts only shown once the full measurement is valid
					{primary_above_limit_n, primary_within_limit_n, primary_below_limit_n} <=
						meas_done ? pri_n : 3'h7; // R5 R18 R10
					{secondary_above_limit_n, secondary_within_limit_n, secondary_below_limit_n} <=
						meas_done ? sec_n : 3'h7; // R6 R18
					// Contact failure uses the same strobe path
					no_contact_n <= ~(meas_done & ctrl[`HRI_CTRL_CC_EN] &
						result[`HRI_RES_NC]); // R7 R13 R16
					analog_done_n <= ~analog_phase_done; // R9 R19
					result_valid_n <= ~meas_done; // R11 R4
				end else begin
					{primary_above_limit_n, primary_within_limit_n, primary_below_limit_n} <= 3'h7;
					{secondary_above_limit_n, secondary_within_limit_n, secondary_below_limit_n} <= 3'h7;
					no_contact_n <= 1'b1;
					analog_done_n <= 1'b1;
					result_valid_n <= 1'b1;
				end
			end
		end
	end

	// ************
	// Bus read path
	// ************
	always @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `HRI_RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `HRI_RESP_OKAY;
			if (s_axi_araddr == `HRI_REG_CTRL) begin
				s_axi_rdata <= {29'h0, ctrl};
			end else if (s_axi_araddr == `HRI_REG_STATUS) begin
				s_axi_rdata <= {25'h0, keys_locked, alarm_now, halted, meas_done,
					analog_phase_done, busy, ~trig_n_s};
			end else if (s_axi_araddr == `HRI_REG_IRQ_STAT) begin
				s_axi_rdata <= {28'h0, irq_stat};
			end else if (s_axi_araddr == `HRI_REG_IRQ_MASK) begin
				s_axi_rdata <= {28'h0, irq_mask};
			end else if (s_axi_araddr == `HRI_REG_RESULT) begin
				s_axi_rdata <= {27'h0, result};
			end else if (s_axi_araddr == `HRI_REG_CMD) begin
				s_axi_rdata <= 32'h0;
			end else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= `HRI_RESP_SLVERR;
			end
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// *** verif/hri_check_monitor.sv ***
// Checker for the handler pins of hri_top
// Assumes it is bound into hri_top and sees only its ports
module hri_check (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic key_lock_in_n,
	input wire logic keys_locked,
	input wire logic measure_start,
	input wire logic primary_above_limit_n,
	input wire logic primary_within_limit_n,
	input wire logic primary_below_limit_n,
	input wire logic secondary_above_limit_n,
	input wire logic secondary_within_limit_n,
	input wire logic secondary_below_limit_n,
	input wire logic no_contact_n,
	input wire logic analog_done_n,
	input wire logic result_valid_n
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [2:0] pri = {primary_above_limit_n, primary_within_limit_n, primary_below_limit_n};
	wire [2:0] sec = {secondary_above_limit_n, secondary_within_limit_n, secondary_below_limit_n};
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// ****
	// Properties
	// ****
	property p_pri; $onehot0(~pri); endproperty
	property p_sec; $onehot0(~sec); endproperty
	// Pin passes a two-flop synchroniser first
	property p_lock; $fell(key_lock_in_n) |-> ##[1:4] keys_locked; endproperty
	property p_unlock; $rose(key_lock_in_n) |-> ##[1:4] !keys_locked; endproperty
	property p_pulse; measure_start |=> !measure_start; endproperty
	property p_restart; measure_start |-> ##[1:3] (analog_done_n && result_valid_n); endproperty
	property p_valid; result_valid_n |-> &{pri, sec, no_contact_n}; endproperty
	property p_index; !result_valid_n |-> !analog_done_n; endproperty
	a_pri: assert property (p_pri) else $error("two primary verdicts");
	a_sec: assert property (p_sec) else $error("two secondary verdicts");
	a_lock: assert property (p_lock) else $error("keys not locked");
	a_unlock: assert property (p_unlock) else $error("keys stay locked");
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	a_restart: assert property (p_restart) else $error("strobes not cleared");
	a_valid: assert property (p_valid) else $error("verdict without end");
	a_index: assert property (p_index) else $error("end without index");
	c_start: cover property (measure_start);
	c_end: cover property ($fell(result_valid_n));
	c_lock: cover property (keys_locked);
endmodule

bind hri_top hri_check u_hri_check (.*);

// *** verif/hri_handler.sv ***
// Handler model: trigger pulses, lockout level, result capture
// Assumes one clock shared with the device under test
module hri_handler #(parameter int PW = 260) (
	input wire logic core_clk,
	input wire logic fire,
	input wire logic lock,
	input wire logic result_valid_n,
	input wire logic [6:0] verdict_n,
	output logic measure_start_in_n,
	output logic key_lock_in_n,
	output logic [6:0] seen_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial begin
		measure_start_in_n = 1'h1;
		key_lock_in_n = 1'h1;
		seen_n = 7'h7f;
	end
	always @(posedge core_clk) begin
		key_lock_in_n <= !lock;
		if (fire && cnt == 0) begin
			cnt <= PW;
			measure_start_in_n <= 1'h0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1) begin
			// Low for more than 1 us before the rise
			cnt <= 0;
			measure_start_in_n <= 1'h1;
		end
		// Verdicts are taken only once the end strobe is low
		if (!result_valid_n) seen_n <= verdict_n;
	end
endmodule

// *** verif/handler_result_interface_bench.sv ***
// Self-checking bench for hri_top with a handler model on its pins
// Assumes the register map and timing of the design hand-over
module handler_result_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = 260;
	logic core_clk = 0, srst = 1, fire = 0, lock = 0, power_fail = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rv;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic measure_start_in_n, key_lock_in_n, keys_locked, measure_start, irq, alarm_n;
	wire logic primary_above_limit_n, primary_within_limit_n, primary_below_limit_n;
	wire logic secondary_above_limit_n, secondary_within_limit_n, secondary_below_limit_n;
	wire logic no_contact_n, analog_done_n, result_valid_n;
	wire logic [6:0] seen_n;
	wire logic [6:0] vd = {primary_above_limit_n, primary_within_limit_n, primary_below_limit_n,
		secondary_above_limit_n, secondary_within_limit_n, secondary_below_limit_n, no_contact_n};
	logic [1:0] rr, br;
	bit got;
	int n_errors = 0, checks_done = 0;
	// Rows: control, result word, expected verdict pins
	logic [2:0] t_c [5] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h3};
	logic [4:0] t_r [5] = '{5'h04, 5'h19, 5'h02, 5'h0f, 5'h10};
	logic [6:0] t_e [5] = '{7'h57, 7'h3c, 7'h6b, 7'h7f, 7'h5b};

	hri_top u_hri_top (.s_axi_wstrb(4'hf), .*);
	hri_handler #(.PW(PW)) u_hri_handler (.core_clk(core_clk), .fire(fire), .lock(lock),
		.result_valid_n(result_valid_n), .verdict_n(vd), .measure_start_in_n(measure_start_in_n),
		.key_lock_in_n(key_lock_in_n), .seen_n(seen_n));

	initial forever #2 core_clk = ~core_clk;

	// ****
	// Tasks
	// ****
	task automatic tally_and_finish;
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic hang;
		n_errors++;
		tally_and_finish;
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		br = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (i == 40) hang;
	endtask
	task automatic rd(input logic [7:0] a);
		int i;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (i == 40) hang;
	endtask
	// A missing start is legal here; callers judge it
	task automatic trig(output bit ok);
		int i;
		@(posedge core_clk);
		fire <= 1'h1;
		@(posedge core_clk);
		fire <= 1'h0;
		ok = 0;
		for (i = 0; i < PW + 20 && !ok; i++) begin
			@(posedge core_clk);
			ok = measure_start;
		end
	endtask
	task automatic run(input logic [2:0] c, input logic [4:0] res, input logic [6:0] exp);
		int i;
		wr(8'h00, {29'h0, c});
		trig(got);
		chk(got, 1'h1);
		tk(3);
		chk({analog_done_n, result_valid_n}, 2'h3);
		wr(8'h10, {27'h0, res});
		wr(8'h14, 32'h1);
		tk(3);
		chk({analog_done_n, result_valid_n, vd}, 9'h0ff);
		wr(8'h14, 32'h2);
		for (i = 0; i < 40 && result_valid_n !== 1'h0; i++) @(posedge core_clk);
		if (i == 40) hang;
		tk(1);
		chk(seen_n, exp);
		chk(analog_done_n, 1'h0);
	endtask

	// ****
	// Sequence
	// ****
	initial begin
		tk(10);
		srst <= 1'h0;
		chk({vd, analog_done_n, result_valid_n, alarm_n, keys_locked, irq}, 12'hffc);
		rd(8'h00);
		chk(rv, 32'h0);
		for (int k = 0; k < 5; k++) run(t_c[k], t_r[k], t_e[k]);
		wr(8'h00, 32'h6);
		trig(got);
		chk(got, 1'h0);
		rd(8'h08);
		wr(8'h00, 32'h1);
		trig(got);
		wr(8'h14, 32'h2);
		tk(3);
		chk({analog_done_n, result_valid_n, vd, irq}, 10'h3fe);
		wr(8'h0c, 32'h1);
		tk(3);
		chk(irq, 1'h1);
		rd(8'h08);
		chk({rr, rv}, 34'h7);
		tk(3);
		chk(irq, 1'h0);
		rd(8'h40);
		chk({rr, rv}, 34'h200000000);
		wr(8'h40, 32'h0);
		chk(br, 2'h2);
		wr(8'h0c, 32'h1);
		chk(br, 2'h0);
		lock <= 1'h1;
		tk(6);
		chk(keys_locked, 1'h1);
		lock <= 1'h0;
		tk(6);
		chk(keys_locked, 1'h0);
		power_fail <= 1'h1;
		tk(3);
		chk(alarm_n, 1'h0);
		power_fail <= 1'h0;
		run(3'h7, t_r[1], t_e[1]);
		wr(8'h14, 32'h8);
		trig(got);
		chk(got, 1'h0);
		chk({vd, result_valid_n, alarm_n}, {t_e[1], 2'h0});
		srst <= 1'h1;
		tk(3);
		srst <= 1'h0;
		chk({vd, result_valid_n}, 8'hff);
		tally_and_finish;
	end
endmodule
